// file: shared/detc_params.svh
// constants for the external trigger control block
`ifndef DETC_PARAMS_SVH
`define DETC_PARAMS_SVH
`define DETC_CLK_PERIOD_NS 10
`define DETC_STROBE_MIN_NS 500
`define DETC_STROBE_CYCLES \
   ((`DETC_STROBE_MIN_NS + `DETC_CLK_PERIOD_NS - 1) / `DETC_CLK_PERIOD_NS)
`define DETC_STROBE_CNT_W 7
`define DETC_SCAN_PULSE_CYCLES 2
`define DETC_SCAN_CNT_W 2
`endif

// file: shared/detc_pkg.sv
// types for the external trigger control block
package detc_pkg;
   typedef enum logic [1:0] {
      ACQ_IDLE,
      ACQ_ARMED,
      ACQ_PRE,
      ACQ_POST
   } detc_acq_t;

   // synchronised external inputs, all active low as on the pins
   typedef struct packed {
      logic trig_n;
      logic gate_n;
      logic conv_n;
      logic upd_n;
   } detc_pins_t;

   typedef struct packed {
      logic dac_load;
      logic timed_irq;
      logic conv_start;
      logic pre_phase;
      logic post_phase;
   } detc_events_t;
endpackage

// file: verilog/detc_trigger_ctrl.sv
// external trigger, gate, convert, strobe and scan pulse control
//
// Behaviour
// - one scan pulse per conversion while a scanning mode is active
// - scan pulse rising edge marks when input may be switched
// - strobe write drives strobe output low at least 500 ns
// - post-trigger mode starts sequence on trigger falling edge
// - pre-trigger mode: first edge starts pre, second starts post
// - conversions suppressed while gate input low, allowed while high
// - conversion request falling edge performs one conversion
// - request edges ignored outside a sequence or while gated
// - timer trigger edge loads both analog outputs when selected in posted mode
// - timer trigger edge raises timed interrupt when enabled
`timescale 1ns/1ps
`include "detc_params.svh"

module detc_trigger_ctrl (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_acquisition_trigger_n,
   input wire logic i_conversion_gate_n,
   input wire logic i_conversion_request_n,
   input wire logic i_output_update_trigger_n,
   input wire logic i_scan_mode,
   input wire logic i_pretrigger_mode,
   input wire logic i_acq_arm,
   input wire logic i_acq_stop,
   input wire logic i_strobe_write,
   input wire logic i_timer_trig_select,
   input wire logic i_posted_update,
   input wire logic i_timed_irq_enable,
   input wire logic i_timed_irq_clear,
   output logic o_conversion_scan_pulse,
   output logic o_software_strobe_out_n,
   output logic o_conversion_start,
   output logic o_dac_load,
   output logic o_timed_irq,
   output detc_pkg::detc_acq_t o_acq_state
);
   import detc_pkg::*;

   localparam int STB_CYC = `DETC_STROBE_CYCLES;
   localparam int SCAN_CYC = `DETC_SCAN_PULSE_CYCLES;

   // ========================================
   // state record
   typedef struct packed {
      detc_pins_t sync1;
      detc_pins_t sync2;
      detc_pins_t prev;
      detc_acq_t acq;
      logic [`DETC_STROBE_CNT_W-1:0] stb_cnt;
      logic [`DETC_SCAN_CNT_W-1:0] scan_cnt;
      logic strobe_n;
      logic scan;
      logic conv;
      logic dac_load;
      logic irq;
   } detc_state_t;

   detc_state_t state_reg;
   detc_state_t state_next;
   detc_events_t ev;

   // falling edge of a synchronised active-low line
   function automatic logic fell(input logic prev_v, input logic now_v);
      fell = prev_v & ~now_v;
   endfunction

   // ========================================
   // next-state logic
   always_comb begin
      state_next = state_reg;
      ev = '0;
      // two-stage synchroniser; first stage only feeds second
      state_next.sync1 = '{trig_n: i_acquisition_trigger_n,
                           gate_n: i_conversion_gate_n,
                           conv_n: i_conversion_request_n,
                           upd_n: i_output_update_trigger_n};
      state_next.sync2 = state_reg.sync1;
      state_next.prev = state_reg.sync2; // one action per edge

      // acquisition sequencing
      case (state_reg.acq)
         ACQ_IDLE: begin
            if (i_acq_arm) begin
               state_next.acq = ACQ_ARMED;
            end
         end
         ACQ_ARMED: begin
            if (fell(state_reg.prev.trig_n, state_reg.sync2.trig_n)) begin
               if (i_pretrigger_mode) begin
                  state_next.acq = ACQ_PRE;
                  ev.pre_phase = 1'b1;
               end else begin
                  state_next.acq = ACQ_POST;
                  ev.post_phase = 1'b1;
               end
            end
         end
         ACQ_PRE: begin
            if (fell(state_reg.prev.trig_n, state_reg.sync2.trig_n)) begin
               state_next.acq = ACQ_POST; // second edge
               ev.post_phase = 1'b1;
            end
         end
         ACQ_POST: begin
            state_next.acq = ACQ_POST;
         end
         default: begin
            state_next.acq = ACQ_IDLE;
         end
      endcase
      if (i_acq_stop) begin
         state_next.acq = ACQ_IDLE;
      end

      // conversion on request edge, only in sequence and ungated
      ev.conv_start = fell(state_reg.prev.conv_n, state_reg.sync2.conv_n)
                      && (state_reg.acq == ACQ_PRE
                          || state_reg.acq == ACQ_POST)
                      && state_reg.sync2.gate_n;
      state_next.conv = ev.conv_start;

      // scan pulse: low while converting, rises when sample taken
      if (ev.conv_start && i_scan_mode) begin
         state_next.scan = 1'b0;
         state_next.scan_cnt = `DETC_SCAN_CNT_W'(SCAN_CYC);
      end else if (state_reg.scan_cnt != '0) begin
         state_next.scan_cnt = state_reg.scan_cnt - 1'b1;
         state_next.scan = (state_reg.scan_cnt == 1) ? 1'b1 : 1'b0;
      end else begin
         state_next.scan = 1'b1; // rising edge frees input
      end

      // software strobe low pulse, retriggered by each write
      if (i_strobe_write) begin
         state_next.strobe_n = 1'b0;
         state_next.stb_cnt = `DETC_STROBE_CNT_W'(STB_CYC - 1);
      end else if (state_reg.stb_cnt != '0) begin
         state_next.stb_cnt = state_reg.stb_cnt - 1'b1;
      end else begin
         state_next.strobe_n = 1'b1;
      end

      // timer trigger: posted analog output load and timed interrupt
      ev.dac_load = fell(state_reg.prev.upd_n, state_reg.sync2.upd_n)
                    && i_timer_trig_select && i_posted_update;
      ev.timed_irq = fell(state_reg.prev.upd_n, state_reg.sync2.upd_n)
                     && i_timed_irq_enable;
      state_next.dac_load = ev.dac_load;
      // set wins over clear
      if (ev.timed_irq) begin
         state_next.irq = 1'b1;
      end else if (i_timed_irq_clear) begin
         state_next.irq = 1'b0;
      end
   end

   // ========================================
   // state register
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_reg <= '0;
         state_reg.sync1 <= '1;
         state_reg.sync2 <= '1;
         state_reg.prev <= '1;
         state_reg.acq <= ACQ_IDLE;
         state_reg.strobe_n <= 1'b1;
         state_reg.scan <= 1'b1;
         state_reg.irq <= 1'b0;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state record
   assign o_conversion_scan_pulse = state_reg.scan;
   assign o_software_strobe_out_n = state_reg.strobe_n;
   assign o_conversion_start = state_reg.conv;
   assign o_dac_load = state_reg.dac_load;
   assign o_timed_irq = state_reg.irq;
   assign o_acq_state = state_reg.acq;

   // ========================================
   // checker helper: cycles since the last strobe write, saturating
   localparam int STB_END = STB_CYC + 1;
   logic [`DETC_STROBE_CNT_W-1:0] chk_stb_age_reg;
   logic chk_stb_run;

   // high while the strobe pulse must still be low
   assign chk_stb_run = (chk_stb_age_reg != '0)
                        && (chk_stb_age_reg <= `DETC_STROBE_CNT_W'(STB_CYC));

   // age restarts on each write, stops one past the pulse end
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         chk_stb_age_reg <= '0;
      end else if (i_strobe_write) begin
         chk_stb_age_reg <= `DETC_STROBE_CNT_W'(1);
      end else if (chk_stb_run) begin
         chk_stb_age_reg <= chk_stb_age_reg + 1'b1;
      end
   end

   // ========================================
   // assertions
   sequence s_strobe_go;
      i_strobe_write;
   endsequence

   sequence s_scan_low;
      !o_conversion_scan_pulse [*2];
   endsequence

   a_strobe_low_width: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      s_strobe_go |=> !o_software_strobe_out_n [*8])
      else $error("strobe pulse too short");

   // full pulse width and return, counted by the helper
   a_strobe_held_low: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      chk_stb_run |-> !o_software_strobe_out_n)
      else $error("strobe rose before its minimum width");

   a_strobe_returns_high: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (chk_stb_age_reg == `DETC_STROBE_CNT_W'(STB_END))
         |-> o_software_strobe_out_n)
      else $error("strobe did not return high");

   a_conv_needs_gate: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_conversion_start |-> $past(i_conversion_gate_n, 3))
      else $error("conversion while gated");

   a_conv_in_seq: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_conversion_start |-> ($past(o_acq_state) == ACQ_PRE
                              || $past(o_acq_state) == ACQ_POST))
      else $error("conversion outside sequence");

   a_scan_per_conv: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (o_conversion_start && $past(i_scan_mode))
         |-> s_scan_low ##1 o_conversion_scan_pulse)
      else $error("no scan pulse for conversion");

   a_scan_needs_conv: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      $fell(o_conversion_scan_pulse)
         |-> o_conversion_start && $past(i_scan_mode))
      else $error("scan pulse without a conversion");

   // conversion traced back to a falling edge on the request pin
   a_conv_from_pin: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_conversion_start |-> $past(i_conversion_request_n, 4)
                             && !$past(i_conversion_request_n, 3))
      else $error("conversion without a request edge");

   a_post_on_edge: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (o_acq_state == ACQ_ARMED && !i_pretrigger_mode && !i_acq_stop
       && fell(state_reg.prev.trig_n, state_reg.sync2.trig_n))
         |=> o_acq_state == ACQ_POST)
      else $error("post-trigger start missed");

   a_pre_second_edge: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (o_acq_state == ACQ_PRE && !i_acq_stop
       && fell(state_reg.prev.trig_n, state_reg.sync2.trig_n))
         |=> o_acq_state == ACQ_POST)
      else $error("pre-trigger second edge missed");

   a_dac_load_cause: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_dac_load |-> $past(i_timer_trig_select && i_posted_update)
                     && $past(i_output_update_trigger_n, 4)
                     && !$past(i_output_update_trigger_n, 3))
      else $error("analog output load without cause");

   a_dac_load_on_edge: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (i_timer_trig_select && i_posted_update
       && fell(state_reg.prev.upd_n, state_reg.sync2.upd_n))
         |=> o_dac_load)
      else $error("posted analog output load missed");

   a_irq_on_edge: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (i_timed_irq_enable
       && fell(state_reg.prev.upd_n, state_reg.sync2.upd_n))
         |=> o_timed_irq)
      else $error("timed interrupt not raised");

   // timed interrupt is sticky until cleared
   a_irq_holds: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      (o_timed_irq && !i_timed_irq_clear) |=> o_timed_irq)
      else $error("timed interrupt dropped without clear");

   a_one_conv_edge: assert property (@(posedge i_clk)
      disable iff (i_sys_rst)
      o_conversion_start |=> !o_conversion_start)
      else $error("edge acted on twice");

   a_reset_idle: assert property (@(posedge i_clk)
      $past(i_sys_rst) |-> o_software_strobe_out_n && !o_timed_irq
                           && o_acq_state == ACQ_IDLE)
      else $error("reset state wrong");
endmodule

// file: test/detc_ext_equip.sv
// external equipment model driving the trigger, gate and request pins
`timescale 1ns/1ps
module detc_ext_equip (
   input wire logic i_clk,
   input wire logic [3:0] i_fire,
   input wire logic i_gate_open,
   output detc_pkg::detc_pins_t o_pins
);
   import detc_pkg::*;
   logic [3:0][1:0] low_cnt;
   initial low_cnt = '0;
   // each fired pin goes low for three cycles, then back high
   always @(posedge i_clk) begin
      for (int k = 0; k < 4; k++) begin
         if (i_fire[k]) low_cnt[k] <= #1 2'h3;
         else if (low_cnt[k] != 2'h0) low_cnt[k] <= #1 low_cnt[k] - 2'h1;
      end
   end
   // gate is a plain level, the rest idle high
   assign o_pins = {low_cnt[3] == 2'h0, i_gate_open, low_cnt[1] == 2'h0,
      low_cnt[0] == 2'h0};
endmodule

// file: test/detc_trigger_ctrl_tb.sv
// self-checking bench for the external trigger control block
`timescale 1ns/1ps
`include "detc_params.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
   mismatches++; $display("unexpected %s expected %0h seen %0h", nm, e, g); \
   end end
module detc_trigger_ctrl_tb;
   import detc_pkg::*;
   logic clk, rst, pre, arm, stop, stb, sel, post, en, clr, gate, scn;
   logic [3:0] fire;
   logic [31:0] seed;
   logic scan, strobe_n, conv, load, irq, scan_q;
   detc_pins_t pins;
   detc_acq_t state;
   int mismatches, comparisons, n_conv, n_load, n_scan, n_rise, n_stb;
   detc_ext_equip i_equip (.i_clk(clk), .i_fire(fire), .i_gate_open(gate),
      .o_pins(pins));
   detc_trigger_ctrl i_dut (.i_clk(clk), .i_sys_rst(rst),
      .i_acquisition_trigger_n(pins.trig_n), .i_conversion_gate_n(pins.gate_n),
      .i_conversion_request_n(pins.conv_n),
      .i_output_update_trigger_n(pins.upd_n), .i_scan_mode(scn),
      .i_pretrigger_mode(pre), .i_acq_arm(arm), .i_acq_stop(stop),
      .i_strobe_write(stb), .i_timer_trig_select(sel), .i_posted_update(post),
      .i_timed_irq_enable(en), .i_timed_irq_clear(clr),
      .o_conversion_scan_pulse(scan), .o_software_strobe_out_n(strobe_n),
      .o_conversion_start(conv), .o_dac_load(load), .o_timed_irq(irq),
      .o_acq_state(state));
   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // event counters for the scenario under way
   always @(posedge clk) begin
      n_conv += (conv === 1'b1);
      n_load += (load === 1'b1);
      n_scan += (scan === 1'b0);
      n_rise += (scan === 1'b1 && scan_q === 1'b0);
      n_stb += (strobe_n === 1'b0);
      scan_q = scan;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic clr_cnt();
      {n_conv, n_load, n_scan, n_rise, n_stb} = '0;
   endtask
   // one-cycle pulse on a control input: 0 arm, 1 stop, 2 strobe, 3 clear
   task automatic ctl(input int k);
      @(posedge clk) #1 {arm, stop, stb, clr} = 4'h8 >> k;
      @(posedge clk) #1 {arm, stop, stb, clr} = 4'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   // falling edge on one pin: 3 trig, 1 request, 0 timer trigger
   task automatic hit(input int k);
      clr_cnt();
      @(posedge clk) #1 fire[k] = 1'b1;
      @(posedge clk) #1 fire = 4'h0;
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      final_report();
   end
   // =====================================================
   // main sequence
   initial begin
      {rst, pre, arm, stop, stb, sel, post, en, clr, gate} = 10'h200;
      fire = 4'h0;
      scn = 1'b1;
      seed = 32'h0000205b;
      mismatches = 0;
      comparisons = 0;
      scan_q = 1'b1;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      `CHK("strobe", 1'b1, strobe_n)
      `CHK("irq", 1'b0, irq)
      `CHK("state", ACQ_IDLE, state)
      $display("reset test done");
      clr_cnt();
      ctl(2);
      repeat (16) @(posedge clk);
      ctl(2);
      repeat (80) @(posedge clk);
      #1;
      `CHK("strobe low", 20 + `DETC_STROBE_CYCLES, n_stb)
      `CHK("strobe high", 1'b1, strobe_n)
      $display("strobe test done");
      gate = 1'b1;
      hit(1);
      `CHK("idle conv", 0, n_conv)
      ctl(0);
      `CHK("state", ACQ_ARMED, state)
      hit(3);
      `CHK("state", ACQ_POST, state)
      for (int i = 0; i < 8; i++) begin
         seed = xs(seed);
         gate = (i < 2) ? i[0] : seed[0];
         scn = (i < 2) ? 1'b1 : seed[1];
         repeat (4) @(posedge clk);
         hit(1);
         `CHK("conv", int'(gate), n_conv)
         `CHK("scan low", 2 * int'(gate & scn), n_scan)
         `CHK("scan rise", int'(gate & scn), n_rise)
      end
      $display("post trigger test done");
      ctl(1);
      pre = 1'b1;
      gate = 1'b1;
      ctl(0);
      hit(1);
      `CHK("armed conv", 0, n_conv)
      hit(3);
      `CHK("state", ACQ_PRE, state)
      hit(1);
      `CHK("pre conv", 1, n_conv)
      hit(3);
      `CHK("state", ACQ_POST, state)
      $display("pre trigger test done");
      for (int i = 0; i < 10; i++) begin
         seed = xs(seed);
         {sel, post, en} = (i < 2) ? 3'h7 : seed[2:0];
         hit(0);
         `CHK("dac load", int'(sel & post), n_load)
         `CHK("irq", en, irq)
         ctl(3);
         `CHK("irq", 1'b0, irq)
      end
      $display("timer trigger test done");
      {sel, post, en} = 3'h7;
      hit(0);
      `CHK("irq set", 1'b1, irq)
      ctl(2);
      `CHK("strobe set", 1'b0, strobe_n)
      rst = 1'b1;
      repeat (2) @(posedge clk);
      #1 rst = 1'b0;
      `CHK("strobe", 1'b1, strobe_n)
      `CHK("irq", 1'b0, irq)
      `CHK("state", ACQ_IDLE, state)
      $display("mid-run reset test done");
      final_report();
   end
endmodule
